// ### hrpc_pkg.sv
// Constants for the reset-pin and holdover control registers.
// Assumes a byte-wide serial register port in front of the block.
package hrpc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [12:0] PIN_CTRL_OFS  = 13'h014A;
  localparam logic [12:0] HOLD_CTRL_OFS = 13'h014B;
  localparam logic [12:0] MAN_LOW_OFS   = 13'h014C;
  // ==========================================================
  // Reset values
  localparam logic [7:0] PIN_CTRL_RST  = 8'h02;
  localparam logic [7:0] HOLD_CTRL_RST = 8'h16;
  localparam logic [7:0] MAN_LOW_RST   = 8'h00;
  localparam logic [9:0] TRACK_RST     = 10'h200;
  // ==========================================================
  // Field positions
  localparam int SEL_MSB     = 5;
  localparam int SEL_LSB     = 3;
  localparam int TYPE_MSB    = 2;
  localparam int TYPE_LSB    = 0;
  localparam int TMO_MSB     = 7;
  localparam int TMO_LSB     = 6;
  localparam int ABS_EN_BIT  = 5;
  localparam int TRACK_BIT   = 4;
  localparam int FORCE_BIT   = 3;
  localparam int MANUAL_BIT  = 2;
  localparam int MAN_HI_MSB  = 1;
  localparam int MAN_HI_LSB  = 0;
  // ==========================================================
  // Pin output selector codes
  localparam logic [2:0] SEL_LOW      = 3'h0;
  localparam logic [2:0] SEL_THIRD    = 3'h2;
  localparam logic [2:0] SEL_LOCKED   = 3'h3;
  localparam logic [2:0] SEL_DAC_LOW  = 3'h4;
  localparam logic [2:0] SEL_DAC_HIGH = 3'h5;
  localparam logic [2:0] SEL_READBACK = 3'h6;
  // ==========================================================
  // Pin type codes
  localparam logic [2:0] TYPE_IN      = 3'h0;
  localparam logic [2:0] TYPE_IN_PU   = 3'h1;
  localparam logic [2:0] TYPE_IN_PD   = 3'h2;
  localparam logic [2:0] TYPE_PP      = 3'h3;
  localparam logic [2:0] TYPE_PP_INV  = 3'h4;
  localparam logic [2:0] TYPE_OD      = 3'h6;
endpackage : hrpc_pkg

// ### hrpc_ctrl.sv
// Reset-pin configuration and holdover control register bank.
// Assumes register writes and reads arrive as one-cycle strobes
// from the serial control port, synchronous to core_clk_i.
//
// Notes on behaviour
// - Selector bits 5:3: low, third ref, DAC locked/low/high, readback.
// - Selector only drives the pin in output types; ignored in input types.
// - Type bits 2:0: in, pull-up, pull-down, push-pull, inverted, open-drain.
// - In any input type a high pin level holds the device in reset.
// - Bits 7:6 set the signal-absent timeout, codes 0 to 3.
// - Bit 5 enables signal-absent detection.
// - Bit 4 enables tuning tracking; tracked code starts at 512 after reset.
// - Tracked code updates only while the first stage PLL is locked.
// - Tracking runs in every mode, holdover or not.
// - Bit 3 forces holdover; clearing it releases the force.
// - Forced holdover drives manual value if manual, else last tracked value.
// - Bit 2 selects manual (1) or tracked (0) DAC source while forced; resets manual.
// - Bits 1:0 are manual value high bits, reset value 2.
// - Manual value is 10 bits; low byte lives in the next register.
`timescale 1ns/1ps
module hrpc_ctrl #(
  parameter int ADDR_W = 13
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              wr_en_i,
  input  wire logic              rd_en_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wr_data_i,
  output logic      [7:0]        rd_data_o,
  output logic                   rd_valid_o,
  input  wire logic              pin_i,
  output logic                   pin_o,
  output logic                   pin_oe_o,
  output logic                   pin_pull_up_o,
  output logic                   pin_pull_down_o,
  output logic                   device_reset_o,
  input  wire logic              third_ref_input_sel_i,
  input  wire logic              dac_locked_i,
  input  wire logic              dac_low_i,
  input  wire logic              dac_high_i,
  input  wire logic              readback_data_i,
  input  wire logic              first_stage_pll_locked_i,
  input  wire logic              tune_valid_i,
  input  wire logic [9:0]        tune_code_i,
  output logic      [1:0]        signal_absent_timeout_o,
  output logic                   signal_absent_detect_enable_o,
  output logic                   holdover_o,
  output logic      [9:0]        dac_code_o
);

  // ==========================================================
  // Register storage
  logic [5:0] pin_ctrl_r;
  logic [7:0] hold_ctrl_r;
  logic [7:0] man_low_r;
  logic [9:0] track_code_r;

  wire wr_pin  = wr_en_i && (addr_i == ADDR_W'(hrpc_pkg::PIN_CTRL_OFS));
  wire wr_hold = wr_en_i && (addr_i == ADDR_W'(hrpc_pkg::HOLD_CTRL_OFS));
  wire wr_low  = wr_en_i && (addr_i == ADDR_W'(hrpc_pkg::MAN_LOW_OFS));

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_ctrl_r  <= hrpc_pkg::PIN_CTRL_RST[5:0];
      hold_ctrl_r <= hrpc_pkg::HOLD_CTRL_RST;
      man_low_r   <= hrpc_pkg::MAN_LOW_RST;
    end else begin
      if (wr_pin) pin_ctrl_r <= wr_data_i[5:0];
      if (wr_hold) hold_ctrl_r <= wr_data_i;
      if (wr_low) man_low_r <= wr_data_i;
    end
  end

  // ==========================================================
  // Field decode
  wire [2:0] sel_f  = pin_ctrl_r[hrpc_pkg::SEL_MSB:hrpc_pkg::SEL_LSB];
  wire [2:0] type_f = pin_ctrl_r[hrpc_pkg::TYPE_MSB:hrpc_pkg::TYPE_LSB];
  wire       track_en_f = hold_ctrl_r[hrpc_pkg::TRACK_BIT];
  wire       force_f    = hold_ctrl_r[hrpc_pkg::FORCE_BIT];
  wire       manual_f   = hold_ctrl_r[hrpc_pkg::MANUAL_BIT];
  wire [9:0] man_value  = {hold_ctrl_r[hrpc_pkg::MAN_HI_MSB:
                                       hrpc_pkg::MAN_HI_LSB],
                           man_low_r};

  function automatic logic is_input(input logic [2:0] t);
    is_input = (t == hrpc_pkg::TYPE_IN) || (t == hrpc_pkg::TYPE_IN_PU) ||
               (t == hrpc_pkg::TYPE_IN_PD);
  endfunction : is_input

  // ==========================================================
  // Pin selector and driver
  logic sel_sig;
  always_comb begin
    case (sel_f)
      hrpc_pkg::SEL_LOW:      sel_sig = 1'b0;
      hrpc_pkg::SEL_THIRD:    sel_sig = third_ref_input_sel_i;
      hrpc_pkg::SEL_LOCKED:   sel_sig = dac_locked_i;
      hrpc_pkg::SEL_DAC_LOW:  sel_sig = dac_low_i;
      hrpc_pkg::SEL_DAC_HIGH: sel_sig = dac_high_i;
      hrpc_pkg::SEL_READBACK: sel_sig = readback_data_i;
      default:                sel_sig = 1'b0;
    endcase
  end

  wire in_mode  = is_input(type_f);
  wire pp_mode  = (type_f == hrpc_pkg::TYPE_PP);
  wire inv_mode = (type_f == hrpc_pkg::TYPE_PP_INV);
  wire od_mode  = (type_f == hrpc_pkg::TYPE_OD);

  wire pin_nxt    = inv_mode ? ~sel_sig :
                    pp_mode  ? sel_sig : 1'b0;
  wire pin_oe_nxt = pp_mode || inv_mode ||
                    (od_mode && !sel_sig);
  wire rst_nxt    = in_mode && pin_i;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o           <= 1'b0;
      pin_oe_o        <= 1'b0;
      pin_pull_up_o   <= 1'b0;
      pin_pull_down_o <= 1'b0;
      device_reset_o  <= 1'b0;
    end else begin
      pin_o           <= pin_nxt;
      pin_oe_o        <= pin_oe_nxt;
      pin_pull_up_o   <= (type_f == hrpc_pkg::TYPE_IN_PU);
      pin_pull_down_o <= (type_f == hrpc_pkg::TYPE_IN_PD);
      device_reset_o  <= rst_nxt;
    end
  end

  // ==========================================================
  // Tuning tracking and holdover DAC source
  wire track_upd = track_en_f && first_stage_pll_locked_i &&
                   tune_valid_i;
  wire [9:0] dac_nxt = (force_f && manual_f) ? man_value
                                             : track_code_r;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      track_code_r <= hrpc_pkg::TRACK_RST;
      dac_code_o   <= hrpc_pkg::TRACK_RST;
      holdover_o   <= 1'b0;
    end else begin
      if (track_upd) track_code_r <= tune_code_i;
      dac_code_o   <= dac_nxt;
      holdover_o   <= force_f;
    end
  end

  // ==========================================================
  // Signal-absent controls
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      signal_absent_timeout_o       <= 2'h0;
      signal_absent_detect_enable_o <= 1'b0;
    end else begin
      signal_absent_timeout_o <=
        hold_ctrl_r[hrpc_pkg::TMO_MSB:hrpc_pkg::TMO_LSB];
      signal_absent_detect_enable_o <=
        hold_ctrl_r[hrpc_pkg::ABS_EN_BIT];
    end
  end

  // ==========================================================
  // Register readback
  wire [7:0] rd_nxt =
    (addr_i == ADDR_W'(hrpc_pkg::PIN_CTRL_OFS))  ? {2'h0, pin_ctrl_r} :
    (addr_i == ADDR_W'(hrpc_pkg::HOLD_CTRL_OFS)) ? hold_ctrl_r :
    (addr_i == ADDR_W'(hrpc_pkg::MAN_LOW_OFS))   ? man_low_r : 8'h00;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i) rd_data_o <= rd_nxt;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence pp_low_s;
    type_f == hrpc_pkg::TYPE_PP && sel_f == hrpc_pkg::SEL_LOW;
  endsequence
  sequence hold_wr_s;
    wr_hold && !wr_pin && !wr_low;
  endsequence
  sequence forced_manual_s;
    force_f && manual_f && !wr_hold && !wr_low;
  endsequence
  sequence track_step_s;
    track_en_f && first_stage_pll_locked_i && tune_valid_i;
  endsequence
  sequence rd_only_s;
    rd_en_i && !wr_en_i;
  endsequence

  sel_low_drive_a: assert property (
    pp_low_s |=> pin_o == 1'b0 && pin_oe_o)
    else $error("push-pull low selection did not drive low");

  input_no_drive_a: assert property (
    in_mode |=> !pin_oe_o)
    else $error("pin driven while in input type");

  pull_cfg_a: assert property (
    type_f == hrpc_pkg::TYPE_IN_PU |=> pin_pull_up_o && !pin_pull_down_o)
    else $error("pull-up not applied");

  pin_reset_a: assert property (
    device_reset_o |-> $past(in_mode && pin_i))
    else $error("device reset without high input pin");

  timeout_field_a: assert property (
    hold_wr_s ##1 !wr_hold |=>
      signal_absent_timeout_o == $past(wr_data_i[7:6], 2))
    else $error("timeout output does not follow written field");

  track_hold_a: assert property (
    !first_stage_pll_locked_i |=> $stable(track_code_r))
    else $error("tracked code moved while PLL unlocked");

  force_manual_a: assert property (
    forced_manual_s ##1 (force_f && manual_f) |=>
      dac_code_o == $past(man_value))
    else $error("forced manual holdover not driving manual value");

  force_track_a: assert property (
    (force_f && !manual_f) |=> dac_code_o == $past(track_code_r))
    else $error("forced auto holdover not driving tracked value");

  inv_drive_a: assert property (
    inv_mode |=> pin_o == !$past(sel_sig) && pin_oe_o)
    else $error("inverted mode not driving complement");

  od_drive_a: assert property (
    od_mode |=> pin_oe_o == !$past(sel_sig) && !pin_o)
    else $error("open-drain mode drive wrong");

  hold_readback_a: assert property (
    rd_en_i && addr_i == ADDR_W'(hrpc_pkg::HOLD_CTRL_OFS) && !wr_en_i
      |=> rd_valid_o && rd_data_o == hold_ctrl_r)
    else $error("holdover register readback mismatch");

  pull_down_a: assert property (
    type_f == hrpc_pkg::TYPE_IN_PD |=> pin_pull_down_o && !pin_pull_up_o)
    else $error("pull-down not applied");

  pin_reset_set_a: assert property (
    in_mode && pin_i |=> device_reset_o)
    else $error("high input pin did not reset device");

  out_no_reset_a: assert property (
    !in_mode |=> !device_reset_o)
    else $error("device reset outside input type");

  pp_drive_a: assert property (
    pp_mode |=> pin_o == $past(sel_sig) && pin_oe_o)
    else $error("push-pull mode not driving selected signal");

  abs_enable_a: assert property (
    hold_wr_s ##1 !wr_hold |=>
      signal_absent_detect_enable_o ==
        $past(wr_data_i[hrpc_pkg::ABS_EN_BIT], 2))
    else $error("detect enable does not follow written bit");

  force_out_a: assert property (
    hold_wr_s ##1 !wr_hold |=>
      holdover_o == $past(wr_data_i[hrpc_pkg::FORCE_BIT], 2))
    else $error("holdover output does not follow force bit");

  track_update_a: assert property (
    track_step_s |=> track_code_r == $past(tune_code_i))
    else $error("tracked code did not take tuning sample");

  track_off_a: assert property (
    !track_en_f |=> $stable(track_code_r))
    else $error("tracked code moved while tracking disabled");

  track_mon_a: assert property (
    !force_f |=> dac_code_o == $past(track_code_r))
    else $error("DAC code not showing tracked value");

  low_write_a: assert property (
    wr_low |=> man_low_r == $past(wr_data_i))
    else $error("manual low byte write lost");

  man_high_a: assert property (
    hold_wr_s |=> man_value[9:8] ==
      $past(wr_data_i[hrpc_pkg::MAN_HI_MSB:hrpc_pkg::MAN_HI_LSB]))
    else $error("manual value high bits do not follow write");

  pin_readback_a: assert property (
    rd_only_s ##0 (addr_i == ADDR_W'(hrpc_pkg::PIN_CTRL_OFS))
      |=> rd_valid_o && rd_data_o == {2'h0, pin_ctrl_r})
    else $error("pin register readback mismatch");

  low_readback_a: assert property (
    rd_only_s ##0 (addr_i == ADDR_W'(hrpc_pkg::MAN_LOW_OFS))
      |=> rd_valid_o && rd_data_o == man_low_r)
    else $error("manual low byte readback mismatch");

  rd_pulse_a: assert property (
    rd_valid_o == $past(rd_en_i))
    else $error("read valid not one cycle after strobe");

endmodule : hrpc_ctrl

// ### hrpc_ctrl_tb_top.sv
// Self-checking bench for the reset-pin and holdover register bank.
// Assumes the bank stands alone; the bench drives every port itself.
`timescale 1ns/1ps
module hrpc_ctrl_tb_top;
  typedef struct packed {
    logic [7:0] wdat;
    logic [4:0] stat;
    logic [4:0] expv;
  } hrpc_row_s;
  // ==========================================================
  // Stimulus and observed signals
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wr_en, rd_en, ext_pin, pll, tvalid;
  logic [12:0] addr;
  logic [7:0]  wdata, rd_data;
  logic [4:0]  stat;
  logic [9:0]  tcode, dac;
  logic        rd_valid, pin_o, pin_oe, pu, pd, dev_rst, hold, abs_en;
  logic [1:0]  tmo;
  wire         pin_w = pin_oe ? pin_o : ext_pin;
  int          n_errors = 0;
  int          n_tests = 0;
  hrpc_row_s   rows [15];
  always #2.5 core_clk_i = ~core_clk_i;
  hrpc_ctrl hrpc_ctrl_i (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .addr_i(addr), .wr_data_i(wdata),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .pin_i(pin_w),
    .pin_o(pin_o), .pin_oe_o(pin_oe), .pin_pull_up_o(pu),
    .pin_pull_down_o(pd), .device_reset_o(dev_rst),
    .third_ref_input_sel_i(stat[4]), .dac_locked_i(stat[3]),
    .dac_low_i(stat[2]), .dac_high_i(stat[1]),
    .readback_data_i(stat[0]), .first_stage_pll_locked_i(pll),
    .tune_valid_i(tvalid), .tune_code_i(tcode),
    .signal_absent_timeout_o(tmo),
    .signal_absent_detect_enable_o(abs_en), .holdover_o(hold),
    .dac_code_o(dac));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk_i);
    wr_en <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask : wr
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge core_clk_i);
    rd_en <= 1'b0;
    #1;
    chk({7'h00, rd_valid, rd_data}, {8'h01, e});
  endtask : rd
  task automatic trk(input logic p, input logic [9:0] c, input logic [9:0] e);
    @(posedge core_clk_i);
    pll <= p;
    tcode <= c;
    repeat (3) @(posedge core_clk_i);
    #1;
    chk({6'h00, dac}, {6'h00, e});
  endtask : trk
  task automatic wrap_up;
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // Main sequence
  initial begin
    wr_en = 1'b0; rd_en = 1'b0; addr = 13'h0000; wdata = 8'h00;
    ext_pin = 1'b1; stat = 5'h00; pll = 1'b0; tvalid = 1'b1;
    tcode = 10'h155;
    rows = '{'{8'h03, 5'h1F, 5'h10}, '{8'h13, 5'h10, 5'h18},
             '{8'h1B, 5'h08, 5'h18}, '{8'h23, 5'h04, 5'h18},
             '{8'h2B, 5'h02, 5'h18}, '{8'h33, 5'h01, 5'h18},
             '{8'h33, 5'h1E, 5'h10}, '{8'h14, 5'h10, 5'h10},
             '{8'h14, 5'h00, 5'h18}, '{8'h1E, 5'h00, 5'h10},
             '{8'h1E, 5'h08, 5'h00}, '{8'h10, 5'h1F, 5'h01},
             '{8'h11, 5'h1F, 5'h05}, '{8'h12, 5'h1F, 5'h03},
             '{8'h06, 5'h1F, 5'h10}};
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    chk({4'h0, pd, pin_oe, dac}, {4'h0, 2'b10, 10'h200});
    rd(hrpc_pkg::PIN_CTRL_OFS, hrpc_pkg::PIN_CTRL_RST);
    rd(hrpc_pkg::HOLD_CTRL_OFS, hrpc_pkg::HOLD_CTRL_RST);
    rd(hrpc_pkg::MAN_LOW_OFS, hrpc_pkg::MAN_LOW_RST);
    wr(13'h0150, 8'hFF);
    rd(13'h0150, 8'h00);
    $display("Reset values done");
    for (int i = 0; i < 15; i++) begin
      @(posedge core_clk_i);
      stat <= rows[i].stat;
      wr(hrpc_pkg::PIN_CTRL_OFS, rows[i].wdat);
      chk({11'h000, pin_oe, pin_oe & pin_o, pu, pd, dev_rst},
          {11'h000, rows[i].expv});
    end
    $display("Pin table done");
    @(posedge core_clk_i);
    ext_pin <= 1'b0;
    wr(hrpc_pkg::PIN_CTRL_OFS, 8'h02);
    chk({15'h0000, dev_rst}, 16'h0000);
    @(posedge core_clk_i);
    ext_pin <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk({15'h0000, dev_rst}, 16'h0001);
    rd(hrpc_pkg::PIN_CTRL_OFS, 8'h02);
    $display("Reset pin input done");
    trk(1'b0, 10'h155, 10'h200);
    trk(1'b1, 10'h155, 10'h155);
    trk(1'b0, 10'h2AA, 10'h155);
    wr(hrpc_pkg::MAN_LOW_OFS, 8'hAB);
    for (int i = 0; i < 4; i++) begin
      wr(hrpc_pkg::HOLD_CTRL_OFS, {i[1:0], i[0], 5'h1D});
      chk({2'b00, tmo, abs_en, hold, dac},
          {2'b00, i[1:0], i[0], 1'b1, 10'h1AB});
      rd(hrpc_pkg::HOLD_CTRL_OFS, {i[1:0], i[0], 5'h1D});
    end
    wr(hrpc_pkg::HOLD_CTRL_OFS, 8'h18);
    chk({5'h00, hold, dac}, {5'h00, 1'b1, 10'h155});
    wr(hrpc_pkg::HOLD_CTRL_OFS, 8'h14);
    chk({5'h00, hold, dac}, {5'h00, 1'b0, 10'h155});
    @(posedge core_clk_i);
    tvalid <= 1'b0;
    trk(1'b1, 10'h3C3, 10'h155);
    @(posedge core_clk_i);
    tvalid <= 1'b1;
    trk(1'b1, 10'h2AA, 10'h2AA);
    wr(hrpc_pkg::HOLD_CTRL_OFS, 8'h04);
    trk(1'b1, 10'h0F0, 10'h2AA);
    $display("Holdover and tracking done");
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk({6'h00, dac}, {6'h00, 10'h200});
    @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(hrpc_pkg::HOLD_CTRL_OFS, hrpc_pkg::HOLD_CTRL_RST);
    $display("Second reset done");
    wrap_up();
  end
endmodule : hrpc_ctrl_tb_top
